/* design/soft_reset_control_regs.svh */
// Offsets, field positions, reset values and timing counts of the soft reset block.
// Assumes a 100 MHz system clock and a plain address/strobe register port.
`ifndef SOFT_RESET_CONTROL_REGS_SVH
`define SOFT_RESET_CONTROL_REGS_SVH

`define SOFTWARE_RESET_CONTROL_OFFSET 12'h1f8
`define CORE_RESET_BIT 0
`define PORT_ONE_XCVR_RESET_BIT 1
`define PORT_TWO_XCVR_RESET_BIT 2
`define SOFTWARE_RESET_CONTROL_RESET 32'h0000_0000
`define CLK_PERIOD_NS 10
`define XCVR_RESET_HOLD_US 102
`define XCVR_RESET_HOLD_CYCLES ((`XCVR_RESET_HOLD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CORE_RESET_HOLD_CYCLES 16

`endif

/* design/soft_reset_control_pkg.sv */
// Types shared by the soft reset block.
// Assumes the constants header is included where offsets are needed.
package soft_reset_control_pkg;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef enum logic [1:0] {
        CORE_IDLE = 2'b00,
        CORE_HOLD = 2'b01,
        CORE_LOAD = 2'b11
    } core_state_t;

endpackage

/* design/soft_reset_control.sv */
// Soft reset control: self-clearing transceiver and core reset bits with timed holds.
// Assumes host strobes are one cycle, synchronous to clk_sys, and the loader reports done.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "soft_reset_control_regs.svh"

module xcvr_reset_timer (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic start,
    output logic busy
);
    localparam logic [13:0] HOLD = 14'(`XCVR_RESET_HOLD_CYCLES);
    logic [13:0] count_reg;
    logic [13:0] count_next;
    logic busy_reg;
    logic busy_next;

    always_comb begin
        count_next = count_reg;
        busy_next = busy_reg;
        if (!busy_reg && start) begin
            busy_next = 1'b1;
            count_next = HOLD - 14'h0001;
        end else if (busy_reg) begin
            if (count_reg == 14'h0000) begin
                busy_next = 1'b0;
            end else begin
                count_next = count_reg - 14'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count_reg <= 14'h0000;
            busy_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            busy_reg <= busy_next;
        end
    end

    assign busy = busy_reg;

    property p_hold_len;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(busy_reg) |-> busy_reg [*8];
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("reset hold too short");

    // Cycles actually spent in reset, for the minimum hold check
    logic [13:0] held_reg;
    logic [13:0] held_next;

    always_comb begin
        held_next = 14'h0000;
        if (busy_reg && held_reg != 14'h3fff) begin
            held_next = held_reg + 14'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            held_reg <= 14'h0000;
        end else begin
            held_reg <= held_next;
        end
    end

    property p_hold_min;
        @(posedge clk_sys) disable iff (!nrst)
        $fell(busy_reg) |-> held_reg >= HOLD;
    endproperty
    a_hold_min: assert property (p_hold_min) else $error("hold below minimum");
endmodule

////////////////////////////////////////////////////////////////////////////////

module soft_reset_control (
    input wire logic clk_sys,
    input wire logic nrst,
    input soft_reset_control_pkg::reg_req_t host_req,
    input wire logic loader_wr,
    input wire logic [11:0] loader_addr,
    input wire logic [31:0] loader_wdata,
    input wire logic loader_busy,
    output logic [31:0] rdata,
    output logic port_one_xcvr_reset,
    output logic port_two_xcvr_reset,
    output logic core_reset_n,
    output logic exempt_keep,
    output logic cfg_cmd_abort,
    output logic cfg_reload_start,
    output logic ready
);
    import soft_reset_control_pkg::*;

    localparam logic [7:0] CORE_HOLD_LAST = 8'(`CORE_RESET_HOLD_CYCLES - 1);

    logic host_hit;
    logic wr_one;
    logic wr_two;
    logic wr_core;
    logic one_busy;
    logic two_busy;
    core_state_t core_reg;
    core_state_t core_next;
    logic [7:0] core_cnt_reg;
    logic [7:0] core_cnt_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [31:0] ctl_view;

    ////////////////////////////////////////////////////////////////////////////
    // Host write decode; loader writes never reach these bits
    assign host_hit = host_req.wr && (host_req.addr == `SOFTWARE_RESET_CONTROL_OFFSET);
    assign wr_one = host_hit && host_req.wdata[`PORT_ONE_XCVR_RESET_BIT];
    assign wr_two = host_hit && host_req.wdata[`PORT_TWO_XCVR_RESET_BIT];
    assign wr_core = host_hit && host_req.wdata[`CORE_RESET_BIT] && (core_reg == CORE_IDLE);

    // Transceiver timers ignore start while busy
    xcvr_reset_timer u_port_one (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .start(wr_one),
        .busy(one_busy)
    );

    xcvr_reset_timer u_port_two (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .start(wr_two),
        .busy(two_busy)
    );

    assign port_one_xcvr_reset = one_busy;
    assign port_two_xcvr_reset = two_busy;

    ////////////////////////////////////////////////////////////////////////////
    // Core reset sequencer: hold, then configuration reload
    always_comb begin
        core_next = core_reg;
        core_cnt_next = core_cnt_reg;
        case (core_reg)
            CORE_IDLE: begin
                if (wr_core) begin
                    core_next = CORE_HOLD;
                    core_cnt_next = 8'h00;
                end
            end
            CORE_HOLD: begin
                if (core_cnt_reg == CORE_HOLD_LAST) begin
                    core_next = CORE_LOAD;
                end else begin
                    core_cnt_next = core_cnt_reg + 8'h01;
                end
            end
            CORE_LOAD: begin
                if (!loader_busy) begin
                    core_next = CORE_IDLE;
                end
            end
            default: begin
                core_next = CORE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            core_reg <= CORE_IDLE;
            core_cnt_reg <= 8'h00;
        end else begin
            core_reg <= core_next;
            core_cnt_reg <= core_cnt_next;
        end
    end

    // Core domain reset excludes transceivers and clock multiplier
    assign core_reset_n = (core_reg != CORE_HOLD);
    assign exempt_keep = (core_reg == CORE_HOLD);
    assign cfg_cmd_abort = (core_reg == CORE_HOLD);
    assign cfg_reload_start = (core_reg == CORE_HOLD) && (core_cnt_reg == CORE_HOLD_LAST);
    assign ready = (core_reg == CORE_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Read path, always served regardless of core state
    always_comb begin
        ctl_view = 32'h0000_0000;
        ctl_view[`CORE_RESET_BIT] = (core_reg != CORE_IDLE);
        ctl_view[`PORT_ONE_XCVR_RESET_BIT] = one_busy;
        ctl_view[`PORT_TWO_XCVR_RESET_BIT] = two_busy;
        rdata_next = 32'h0000_0000;
        if (host_req.rd && (host_req.addr == `SOFTWARE_RESET_CONTROL_OFFSET)) begin
            rdata_next = ctl_view;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= `SOFTWARE_RESET_CONTROL_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_core_start;
        core_reg == CORE_IDLE && wr_core;
    endsequence

    sequence s_core_held;
        !core_reset_n [*8];
    endsequence

    property p_core_seq;
        @(posedge clk_sys) disable iff (!nrst)
        s_core_start |=> s_core_held;
    endproperty
    a_core_seq: assert property (p_core_seq) else $error("core reset not held");

    property p_abort;
        @(posedge clk_sys) disable iff (!nrst)
        !core_reset_n |-> cfg_cmd_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("command not aborted in core reset");

    property p_reload;
        @(posedge clk_sys) disable iff (!nrst)
        cfg_reload_start |=> core_reg == CORE_LOAD;
    endproperty
    a_reload: assert property (p_reload) else $error("reload did not follow reset");

    property p_xcvr_keep;
        @(posedge clk_sys) disable iff (!nrst)
        !core_reset_n && !port_one_xcvr_reset && !wr_one |=> !port_one_xcvr_reset;
    endproperty
    a_xcvr_keep: assert property (p_xcvr_keep) else $error("core reset hit transceiver");

    property p_two_keep;
        @(posedge clk_sys) disable iff (!nrst)
        !core_reset_n && !port_two_xcvr_reset && !wr_two |=> !port_two_xcvr_reset;
    endproperty
    a_two_keep: assert property (p_two_keep) else $error("core reset hit port two");

    property p_one_start;
        @(posedge clk_sys) disable iff (!nrst)
        wr_one && !one_busy |=> one_busy [*8];
    endproperty
    a_one_start: assert property (p_one_start) else $error("port one reset not held");

    property p_two_start;
        @(posedge clk_sys) disable iff (!nrst)
        wr_two && !two_busy |=> two_busy [*8];
    endproperty
    a_two_start: assert property (p_two_start) else $error("port two reset not held");

    property p_zero_write;
        @(posedge clk_sys) disable iff (!nrst)
        host_hit && !host_req.wdata[`PORT_TWO_XCVR_RESET_BIT] && !two_busy |=> !two_busy;
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write started reset");

    property p_loader;
        @(posedge clk_sys) disable iff (!nrst)
        loader_wr && loader_addr == `SOFTWARE_RESET_CONTROL_OFFSET
        && loader_wdata[`PORT_ONE_XCVR_RESET_BIT] && !host_req.wr && !one_busy |=> !one_busy;
    endproperty
    a_loader: assert property (p_loader) else $error("loader changed reset bit");

    property p_loader_two;
        @(posedge clk_sys) disable iff (!nrst)
        loader_wr && loader_addr == `SOFTWARE_RESET_CONTROL_OFFSET && !host_req.wr && !two_busy
        |=> !two_busy;
    endproperty
    a_loader_two: assert property (p_loader_two) else $error("loader set port two");

    property p_loader_core;
        @(posedge clk_sys) disable iff (!nrst)
        loader_wr && loader_addr == `SOFTWARE_RESET_CONTROL_OFFSET && !host_req.wr && ready
        |=> ready;
    endproperty
    a_loader_core: assert property (p_loader_core) else $error("loader set core bit");

    property p_readback;
        @(posedge clk_sys) disable iff (!nrst)
        host_req.rd && host_req.addr == `SOFTWARE_RESET_CONTROL_OFFSET && core_reg != CORE_IDLE
        |=> rdata[`CORE_RESET_BIT];
    endproperty
    a_readback: assert property (p_readback) else $error("core bit not readable in reset");

    property p_core_clear;
        @(posedge clk_sys) disable iff (!nrst)
        core_reg == CORE_LOAD && !loader_busy |=> ready;
    endproperty
    a_core_clear: assert property (p_core_clear) else $error("core bit did not self clear");

    property p_core_zero;
        @(posedge clk_sys) disable iff (!nrst)
        host_hit && !host_req.wdata[`CORE_RESET_BIT] && core_reg == CORE_IDLE |=> ready;
    endproperty
    a_core_zero: assert property (p_core_zero) else $error("zero started core reset");

    property p_core_ignore;
        @(posedge clk_sys) disable iff (!nrst)
        host_hit && host_req.wdata[`CORE_RESET_BIT] && core_reg == CORE_LOAD && loader_busy
        |=> core_reg == CORE_LOAD;
    endproperty
    a_core_ignore: assert property (p_core_ignore) else $error("rewrite not ignored");

    property p_reload_pulse;
        @(posedge clk_sys) disable iff (!nrst)
        cfg_reload_start |=> !cfg_reload_start;
    endproperty
    a_reload_pulse: assert property (p_reload_pulse) else $error("reload pulse long");

    property p_reserved;
        @(posedge clk_sys) disable iff (!nrst)
        host_req.rd |=> rdata[31:3] == 29'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

    property p_quiet;
        @(posedge clk_sys) disable iff (!nrst)
        !host_req.rd |=> rdata == 32'h0000_0000;
    endproperty
    a_quiet: assert property (p_quiet) else $error("read data without read");

    property p_exempt;
        @(posedge clk_sys) disable iff (!nrst)
        core_reset_n |-> !exempt_keep && !cfg_cmd_abort;
    endproperty
    a_exempt: assert property (p_exempt) else $error("reset controls stuck");
endmodule

/* verification/testbench.sv */
// Self-checking bench for the soft reset block, driven through its host register port.
// Assumes the design header and package are compiled first; the bench drives every input.
`timescale 1ns/1ps
`include "soft_reset_control_regs.svh"

module testbench;
    import soft_reset_control_pkg::*;

    localparam logic [11:0] reg_addr = `SOFTWARE_RESET_CONTROL_OFFSET;
    localparam int hold_cycles = 102 * 1000 / 10;
    localparam int core_cycles = `CORE_RESET_HOLD_CYCLES;

    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    reg_req_t host_req = '0;
    logic loader_wr = 1'b0;
    logic [11:0] loader_addr = 12'h000;
    logic [31:0] loader_wdata = 32'h0000_0000;
    logic loader_busy = 1'b0;
    logic [31:0] rdata;
    logic port_one_xcvr_reset;
    logic port_two_xcvr_reset;
    logic core_reset_n;
    logic exempt_keep;
    logic cfg_cmd_abort;
    logic cfg_reload_start;
    logic ready;
    int n_fail = 0;
    int checks_done = 0;
    int cnt_one = 0;
    int cnt_two = 0;
    int cnt_core = 0;
    int cnt_load = 0;

    soft_reset_control u_soft_reset_control (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .host_req(host_req),
        .loader_wr(loader_wr),
        .loader_addr(loader_addr),
        .loader_wdata(loader_wdata),
        .loader_busy(loader_busy),
        .rdata(rdata),
        .port_one_xcvr_reset(port_one_xcvr_reset),
        .port_two_xcvr_reset(port_two_xcvr_reset),
        .core_reset_n(core_reset_n),
        .exempt_keep(exempt_keep),
        .cfg_cmd_abort(cfg_cmd_abort),
        .cfg_reload_start(cfg_reload_start),
        .ready(ready)
    );

    always #5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////

    // Cycles spent in each reset, and reload pulses, sampled on every rising edge
    always @(posedge clk_sys) begin
        if (port_one_xcvr_reset === 1'b1) cnt_one <= cnt_one + 1;
        if (port_two_xcvr_reset === 1'b1) cnt_two <= cnt_two + 1;
        if (core_reset_n === 1'b0) cnt_core <= cnt_core + 1;
        if (cfg_reload_start === 1'b1) cnt_load <= cnt_load + 1;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        host_req.addr <= a;
        host_req.wdata <= d;
        host_req.wr <= 1'b1;
        @(posedge clk_sys);
        host_req.wr <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        host_req.addr <= a;
        host_req.rd <= 1'b1;
        @(posedge clk_sys);
        host_req.rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    // Bounded wait for ready (sel 0) or port two reset (sel 1); running out ends the run
    task automatic wait_val(input bit sel, input logic val, input int limit);
        logic sig;
        sig = sel ? port_two_xcvr_reset : ready;
        for (int i = 0; i < limit && sig !== val; i++) begin
            @(posedge clk_sys);
            #1;
            sig = sel ? port_two_xcvr_reset : ready;
        end
        if (sig !== val) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, sig, val);
            results();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////

    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        reg_rd(reg_addr, 32'h0000_0000);
        reg_rd(12'h1fc, 32'h0000_0000);
        $display("test defaults done");

        // Core reset with a slow reload, rewrites ignored meanwhile
        @(posedge clk_sys);
        loader_busy <= 1'b1;
        reg_wr(reg_addr, 32'h0000_0001);
        check({28'h0, core_reset_n, cfg_cmd_abort, exempt_keep, ready}, 32'h6);
        reg_wr(reg_addr, 32'h0000_0001);
        reg_wr(reg_addr, 32'h0000_0000);
        reg_rd(reg_addr, 32'h0000_0001);
        repeat (30) @(posedge clk_sys);
        reg_wr(reg_addr, 32'h0000_0001);
        reg_rd(reg_addr, 32'h0000_0001);
        check({31'h0, ready}, 32'h0);
        @(posedge clk_sys);
        loader_busy <= 1'b0;
        wait_val(1'b0, 1'b1, 20);
        reg_rd(reg_addr, 32'h0000_0000);
        check(cnt_core, core_cycles);
        check(cnt_load, 1);
        check({30'h0, port_one_xcvr_reset, port_two_xcvr_reset}, 32'h0);
        $display("test core reset done");

        // Loader write aimed at the reset bits
        @(posedge clk_sys);
        loader_addr <= reg_addr;
        loader_wdata <= 32'h0000_0007;
        loader_wr <= 1'b1;
        @(posedge clk_sys);
        loader_wr <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reg_rd(reg_addr, 32'h0000_0000);
        check({29'h0, core_reset_n, port_one_xcvr_reset, port_two_xcvr_reset}, 32'h4);
        $display("test loader write done");

        // Both port resets, rewritten while set, core reset in mid-hold
        reg_wr(reg_addr, 32'h0000_0006);
        check({30'h0, port_one_xcvr_reset, port_two_xcvr_reset}, 32'h3);
        repeat (100) @(posedge clk_sys);
        reg_wr(reg_addr, 32'h0000_0006);
        reg_rd(reg_addr, 32'h0000_0006);
        reg_wr(reg_addr, 32'h0000_0001);
        wait_val(1'b1, 1'b0, hold_cycles + 200);
        reg_rd(reg_addr, 32'h0000_0000);
        check(cnt_one, hold_cycles);
        check(cnt_two, hold_cycles);
        check(cnt_core, 2 * core_cycles);
        $display("test port resets done");
        results();
    end

endmodule
